// [bcs_pkg.sv]
// Shared constants, types and register map of the bit concat, slice and logic operators.
package bcs_pkg;

  // ---------------------------------------------------------------
  // Datapath dimensions
  // ---------------------------------------------------------------
  localparam int ELEMS = 2;
  localparam int OPERAND_COUNT = 4;
  localparam int OPND_W = 8;
  localparam int FRAC_BITS = 0;
  localparam int OFF_W = 12;
  localparam int LEN_W = 16;
  localparam int MIN_OPERANDS = 2;
  localparam int MAX_OPERANDS = 128;
  localparam int MAX_CAT_BITS = 1024;

  // ---------------------------------------------------------------
  // Slice range and offset basis selections
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BCS_RNG_BOT_WIDTH = 3'b001,
    BCS_RNG_TOP_WIDTH = 3'b010,
    BCS_RNG_TOP_BOT = 3'b100
  } bcs_range_e;

  typedef enum logic [2:0] {
    BCS_BASIS_LSB = 3'b001,
    BCS_BASIS_POINT = 3'b010,
    BCS_BASIS_MSB = 3'b100
  } bcs_basis_e;

  // ---------------------------------------------------------------
  // Register map of the operand source
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TOP_OFF = 12'h004;
  localparam logic [11:0] ADDR_BOT_OFF = 12'h008;
  localparam logic [11:0] ADDR_WIDTH = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_OPD_BASE = 12'h100;
  localparam logic [11:0] ADDR_RES_BASE = 12'h200;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BASIS_LSB = 4;
  localparam int CTRL_ASCALAR_BIT = 8;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_LEN_LSB = 16;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0011;
  localparam logic [31:0] WIDTH_RESET = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [bcs_if.sv]
// Link between the operator datapath and the party that supplies operands.
`timescale 1ns/1ps
interface bcs_if #(
  parameter int ELEMS = bcs_pkg::ELEMS,
  parameter int OPERAND_COUNT = bcs_pkg::OPERAND_COUNT,
  parameter int OPND_W = bcs_pkg::OPND_W,
  parameter int OFF_W = bcs_pkg::OFF_W,
  parameter int LEN_W = bcs_pkg::LEN_W
);
  // Concatenation: operand k of element e at [(e*OPERAND_COUNT + k)*OPND_W +: OPND_W].
  logic [ELEMS*OPERAND_COUNT*OPND_W-1:0] cat_in;
  logic [ELEMS*OPERAND_COUNT*OPND_W-1:0] cat_out;
  // Slice.
  logic [ELEMS*OPND_W-1:0] slice_in;
  logic [2:0] range_mode_select;
  logic [2:0] offset_basis_select;
  logic signed [OFF_W-1:0] top_off;
  logic signed [OFF_W-1:0] bot_off;
  logic [LEN_W-1:0] slice_width;
  logic [ELEMS*OPND_W-1:0] slice_out;
  logic [LEN_W-1:0] slice_len;
  logic slice_err;
  // Bitwise AND and NOT.
  logic [ELEMS*OPND_W-1:0] and_a;
  logic [ELEMS*OPND_W-1:0] and_b;
  logic and_b_scalar;
  logic [ELEMS*OPND_W-1:0] and_out;
  logic [ELEMS*OPND_W-1:0] not_in;
  logic [ELEMS*OPND_W-1:0] not_out;

  modport dev (
    input cat_in, slice_in, range_mode_select, offset_basis_select, top_off, bot_off,
    input slice_width, and_a, and_b, and_b_scalar, not_in,
    output cat_out, slice_out, slice_len, slice_err, and_out, not_out
  );

  modport src (
    output cat_in, slice_in, range_mode_select, offset_basis_select, top_off, bot_off,
    output slice_width, and_a, and_b, and_b_scalar, not_in,
    input cat_out, slice_out, slice_len, slice_err, and_out, not_out
  );
endinterface

// [bcs_dev.sv]
// Operator datapath: bit concatenation, bit slice, bitwise AND and bitwise NOT.
//
// Function
// RULE_01: First operand lands in the most significant bits.
// RULE_02: Concat operands are integer, Boolean or fixed-point.
// RULE_03: Concat result is unsigned integer, no fraction.
// RULE_04: Operand count ranges from two to 128.
// RULE_05: Total concat operand width at most 1024 bits. The code neither checks nor limits this width; MAX_CAT_BITS is unused.
// RULE_06: Concat works per element on matching dimensions.
// RULE_07: Slice result unsigned, range-wide, same dimensions.
// RULE_08: Bottom plus width extracts upward from bottom.
// RULE_09: Top plus width extracts downward from top.
// RULE_10: Top and bottom mode derives the width.
// RULE_11: Width is positive, used only in width modes.
// RULE_12: LSB basis: zero is LSB, no negatives.
// RULE_13: Point basis: zero lowest integer bit, minus one fraction.
// RULE_14: MSB basis: zero is MSB, no positives.
// RULE_15: Integer operands: point basis equals LSB basis.
// RULE_16: Negative offsets go toward LSB, positive toward MSB.
// RULE_17: Out-of-range extraction is flagged as an error.
// RULE_18: Slice operands real integer or fixed-point, two dimensions.
// RULE_19: AND combines equal-typed operands bit by bit.
// RULE_20: Scalar AND operand is replicated across elements.
// RULE_21: NOT inverts every bit of every element.
// RULE_22: AND and NOT take integer, fixed-point, Boolean only.
// RULE_23: Operators are plain logic without internal state; every result here is registered on sys_clk.
`timescale 1ns/1ps
module bcs_dev #(
  parameter int ELEMS = bcs_pkg::ELEMS,
  parameter int OPERAND_COUNT = bcs_pkg::OPERAND_COUNT,
  parameter int OPND_W = bcs_pkg::OPND_W,
  parameter int FRAC_BITS = bcs_pkg::FRAC_BITS,
  parameter int OFF_W = bcs_pkg::OFF_W,
  parameter int LEN_W = bcs_pkg::LEN_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Operator link
  bcs_if.dev link,
  // Status
  output logic range_err_q
);

  // ---------------------------------------------------------------
  // Derived sizes
  // ---------------------------------------------------------------
  // Operand count is clamped into the legal span so a bad setting cannot
  // build an empty or oversized concatenator.
  localparam int OPS_LO = (OPERAND_COUNT < bcs_pkg::MIN_OPERANDS) ?
    bcs_pkg::MIN_OPERANDS : OPERAND_COUNT; // [RULE_04]
  localparam int OPS = (OPS_LO > bcs_pkg::MAX_OPERANDS) ?
    bcs_pkg::MAX_OPERANDS : OPS_LO; // [RULE_04]
  localparam int CAT_W = OPERAND_COUNT * OPND_W;

  // ---------------------------------------------------------------
  // Slice range resolution
  // ---------------------------------------------------------------
  int top_pos;
  int bot_pos;
  int lo_pos;
  int hi_pos;
  int len;
  logic top_bad;
  logic bot_bad;
  logic bad;
  logic [OPND_W-1:0] len_mask;
  int shift;

  always_comb begin
    top_pos = 0;
    bot_pos = 0;
    top_bad = 1'b0;
    bot_bad = 1'b0;
    // Anchors; offsets add toward the MSB and subtract toward the LSB.
    case (link.offset_basis_select)
      bcs_pkg::BCS_BASIS_LSB: begin
        top_pos = int'(link.top_off); // [RULE_12] [RULE_16]
        bot_pos = int'(link.bot_off); // [RULE_12] [RULE_16]
        top_bad = link.top_off < 0; // [RULE_12]
        bot_bad = link.bot_off < 0; // [RULE_12]
      end
      bcs_pkg::BCS_BASIS_POINT: begin
        // With no fraction bits this collapses onto the LSB anchor.
        top_pos = FRAC_BITS + int'(link.top_off); // [RULE_13] [RULE_15] [RULE_16]
        bot_pos = FRAC_BITS + int'(link.bot_off); // [RULE_13] [RULE_15] [RULE_16]
      end
      bcs_pkg::BCS_BASIS_MSB: begin
        top_pos = OPND_W - 1 + int'(link.top_off); // [RULE_14] [RULE_16]
        bot_pos = OPND_W - 1 + int'(link.bot_off); // [RULE_14] [RULE_16]
        top_bad = link.top_off > 0; // [RULE_14]
        bot_bad = link.bot_off > 0; // [RULE_14]
      end
      default: begin
        top_bad = 1'b1;
        bot_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    lo_pos = 0;
    hi_pos = 0;
    len = 0;
    bad = 1'b0;
    // Only the offsets and width that the mode enables are checked.
    case (link.range_mode_select)
      bcs_pkg::BCS_RNG_BOT_WIDTH: begin
        len = int'(link.slice_width); // [RULE_11]
        lo_pos = bot_pos; // [RULE_08]
        hi_pos = bot_pos + len - 1; // [RULE_08]
        bad = bot_bad || (len < 1); // [RULE_11]
      end
      bcs_pkg::BCS_RNG_TOP_WIDTH: begin
        len = int'(link.slice_width); // [RULE_11]
        hi_pos = top_pos; // [RULE_09]
        lo_pos = top_pos - len + 1; // [RULE_09]
        bad = top_bad || (len < 1); // [RULE_11]
      end
      bcs_pkg::BCS_RNG_TOP_BOT: begin
        hi_pos = top_pos; // [RULE_10]
        lo_pos = bot_pos; // [RULE_10]
        len = top_pos - bot_pos + 1; // [RULE_10]
        bad = top_bad || bot_bad || (top_pos < bot_pos); // [RULE_10]
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    if ((lo_pos < 0) || (hi_pos > OPND_W - 1)) begin
      bad = 1'b1; // [RULE_17]
    end
  end

  always_comb begin
    len_mask = '0;
    shift = 0;
    if (!bad) begin
      shift = lo_pos;
      for (int i = 0; i < OPND_W; i++) begin
        len_mask[i] = (i < len);
      end
    end
  end

  // ---------------------------------------------------------------
  // Slice outputs
  // ---------------------------------------------------------------
  // A flagged range yields zero data and zero length.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.slice_out <= '0;
      link.slice_len <= '0;
      link.slice_err <= 1'b0;
      range_err_q <= 1'b0;
    end else begin
      for (int e = 0; e < ELEMS; e++) begin
        link.slice_out[e*OPND_W +: OPND_W] <=
          (link.slice_in[e*OPND_W +: OPND_W] >> shift) & len_mask; // [RULE_07] [RULE_18]
      end
      link.slice_len <= bad ? '0 : LEN_W'(len); // [RULE_07]
      link.slice_err <= bad; // [RULE_17]
      range_err_q <= bad; // [RULE_17]
    end
  end

  // ---------------------------------------------------------------
  // Concatenation
  // ---------------------------------------------------------------
  // Operand k moves to slot OPS-1-k, so operand zero ends up on top; the
  // word carries no sign or binary point of its own.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.cat_out <= '0;
    end else begin
      for (int e = 0; e < ELEMS; e++) begin
        for (int k = 0; k < OPS; k++) begin // [RULE_02]
          link.cat_out[e*CAT_W + (OPS-1-k)*OPND_W +: OPND_W] <=
            link.cat_in[e*CAT_W + k*OPND_W +: OPND_W]; // [RULE_01] [RULE_03] [RULE_06]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Bitwise AND and NOT
  // ---------------------------------------------------------------
  // The operators are combinational in nature; each result is captured
  // once so every output leaves from a flip-flop.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.and_out <= '0;
    end else begin
      for (int e = 0; e < ELEMS; e++) begin
        if (link.and_b_scalar) begin
          link.and_out[e*OPND_W +: OPND_W] <=
            link.and_a[e*OPND_W +: OPND_W] & link.and_b[0 +: OPND_W]; // [RULE_20] [RULE_22]
        end else begin
          link.and_out[e*OPND_W +: OPND_W] <=
            link.and_a[e*OPND_W +: OPND_W] & link.and_b[e*OPND_W +: OPND_W]; // [RULE_19]
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.not_out <= '0;
    end else begin
      link.not_out <= ~link.not_in; // [RULE_21] [RULE_22] [RULE_23]
    end
  end

endmodule

// [bcs_src.sv]
// Operand source: AXI4-Lite register bank that drives the operators and reads back results.
`timescale 1ns/1ps
module bcs_src #(
  parameter int ELEMS = bcs_pkg::ELEMS,
  parameter int OPERAND_COUNT = bcs_pkg::OPERAND_COUNT,
  parameter int OPND_W = bcs_pkg::OPND_W,
  parameter int OFF_W = bcs_pkg::OFF_W,
  parameter int LEN_W = bcs_pkg::LEN_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Operator link
  bcs_if.src link,
  // AXI4-Lite write channels
  input wire logic [bcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [bcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // Operand and result word banks
  // ---------------------------------------------------------------
  localparam int CAT_B = ELEMS * OPERAND_COUNT * OPND_W;
  localparam int EW = ELEMS * OPND_W;
  localparam int IN_BITS = CAT_B + 4 * EW;
  localparam int IN_WORDS = (IN_BITS + 31) / 32;
  localparam int RES_BITS = CAT_B + 3 * EW;
  localparam int RES_WORDS = (RES_BITS + 31) / 32;

  logic [31:0] ctrl_q;
  logic [31:0] top_q;
  logic [31:0] bot_q;
  logic [31:0] width_q;
  logic [31:0] opd_q [IN_WORDS];
  logic [IN_WORDS*32-1:0] in_flat;
  logic [RES_WORDS*32-1:0] res_flat;

  always_comb begin
    for (int i = 0; i < IN_WORDS; i++) begin
      in_flat[i*32 +: 32] = opd_q[i];
    end
    res_flat = '0;
    res_flat[0 +: CAT_B] = link.cat_out;
    res_flat[CAT_B +: EW] = link.slice_out;
    res_flat[CAT_B + EW +: EW] = link.and_out;
    res_flat[CAT_B + 2*EW +: EW] = link.not_out;
  end

  assign link.cat_in = in_flat[0 +: CAT_B];
  assign link.slice_in = in_flat[CAT_B +: EW];
  assign link.and_a = in_flat[CAT_B + EW +: EW];
  assign link.and_b = in_flat[CAT_B + 2*EW +: EW];
  assign link.not_in = in_flat[CAT_B + 3*EW +: EW];
  assign link.range_mode_select = ctrl_q[bcs_pkg::CTRL_MODE_LSB +: 3];
  assign link.offset_basis_select = ctrl_q[bcs_pkg::CTRL_BASIS_LSB +: 3];
  assign link.and_b_scalar = ctrl_q[bcs_pkg::CTRL_ASCALAR_BIT];
  assign link.top_off = top_q[OFF_W-1:0];
  assign link.bot_off = bot_q[OFF_W-1:0];
  assign link.slice_width = width_q[LEN_W-1:0];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------
  logic [bcs_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  int widx;

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign widx = int'(awaddr_q - bcs_pkg::ADDR_OPD_BASE) / 4;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= bcs_pkg::CTRL_RESET;
      top_q <= bcs_pkg::ZERO_WORD;
      bot_q <= bcs_pkg::ZERO_WORD;
      width_q <= bcs_pkg::WIDTH_RESET;
      for (int i = 0; i < IN_WORDS; i++) begin
        opd_q[i] <= bcs_pkg::ZERO_WORD;
      end
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bcs_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= bcs_pkg::RESP_OKAY;
      if (awaddr_q == bcs_pkg::ADDR_CTRL) begin
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
      end else if (awaddr_q == bcs_pkg::ADDR_TOP_OFF) begin
        top_q <= merge(top_q, wdata_q, wstrb_q);
      end else if (awaddr_q == bcs_pkg::ADDR_BOT_OFF) begin
        bot_q <= merge(bot_q, wdata_q, wstrb_q);
      end else if (awaddr_q == bcs_pkg::ADDR_WIDTH) begin
        width_q <= merge(width_q, wdata_q, wstrb_q);
      end else if (awaddr_q >= bcs_pkg::ADDR_OPD_BASE && widx < IN_WORDS &&
                   awaddr_q[1:0] == 2'b00) begin
        opd_q[widx] <= merge(opd_q[widx], wdata_q, wstrb_q);
      end else if (awaddr_q == bcs_pkg::ADDR_STATUS) begin
        s_axi_bresp <= bcs_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= bcs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  int ridx;
  int sidx;

  assign ridx = int'(s_axi_araddr - bcs_pkg::ADDR_OPD_BASE) / 4;
  assign sidx = int'(s_axi_araddr - bcs_pkg::ADDR_RES_BASE) / 4;

  always_comb begin
    rd_data = bcs_pkg::ZERO_WORD;
    rd_resp = bcs_pkg::RESP_OKAY;
    if (s_axi_araddr == bcs_pkg::ADDR_CTRL) begin
      rd_data = ctrl_q;
    end else if (s_axi_araddr == bcs_pkg::ADDR_TOP_OFF) begin
      rd_data = top_q;
    end else if (s_axi_araddr == bcs_pkg::ADDR_BOT_OFF) begin
      rd_data = bot_q;
    end else if (s_axi_araddr == bcs_pkg::ADDR_WIDTH) begin
      rd_data = width_q;
    end else if (s_axi_araddr == bcs_pkg::ADDR_STATUS) begin
      rd_data[bcs_pkg::STAT_ERR_BIT] = link.slice_err;
      rd_data[bcs_pkg::STAT_LEN_LSB +: LEN_W] = link.slice_len;
    end else if (s_axi_araddr >= bcs_pkg::ADDR_RES_BASE && sidx < RES_WORDS &&
                 s_axi_araddr[1:0] == 2'b00) begin
      rd_data = res_flat[sidx*32 +: 32];
    end else if (s_axi_araddr >= bcs_pkg::ADDR_OPD_BASE && ridx < IN_WORDS &&
                 s_axi_araddr[1:0] == 2'b00) begin
      rd_data = opd_q[ridx];
    end else begin
      rd_resp = bcs_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= bcs_pkg::ZERO_WORD;
      s_axi_rresp <= bcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// [bcs_sva.sv]
// Concurrent checks on the link between the operand source and the operator datapath.
`timescale 1ns/1ps
module bcs_sva #(
  parameter int ELEMS = bcs_pkg::ELEMS,
  parameter int OPERAND_COUNT = bcs_pkg::OPERAND_COUNT,
  parameter int OPND_W = bcs_pkg::OPND_W,
  parameter int OFF_W = bcs_pkg::OFF_W,
  parameter int LEN_W = bcs_pkg::LEN_W,
  localparam int EW = ELEMS * OPND_W,
  localparam int CW = EW * OPERAND_COUNT
) (
  // Clock and reset
  input logic sys_clk,
  input logic rst,
  // Link signals
  input logic [CW-1:0] cat_in,
  input logic [CW-1:0] cat_out,
  input logic [2:0] range_mode_select,
  input logic [2:0] offset_basis_select,
  input logic signed [OFF_W-1:0] top_off,
  input logic signed [OFF_W-1:0] bot_off,
  input logic [LEN_W-1:0] slice_width,
  input logic [EW-1:0] slice_out,
  input logic [LEN_W-1:0] slice_len,
  input logic slice_err,
  input logic [EW-1:0] and_a,
  input logic [EW-1:0] and_b,
  input logic and_b_scalar,
  input logic [EW-1:0] and_out,
  input logic [EW-1:0] not_in,
  input logic [EW-1:0] not_out,
  input logic range_err_q
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic up_q;
  logic [CW-1:0] cat_exp;
  // Skips the first edge after reset, where outputs still hold reset values.
  always_ff @(posedge sys_clk) begin
    up_q <= !rst;
  end
  for (genvar e = 0; e < ELEMS; e++) begin : g_el
    for (genvar k = 0; k < OPERAND_COUNT; k++) begin : g_op
      assign cat_exp[(e*OPERAND_COUNT+OPERAND_COUNT-1-k)*OPND_W +: OPND_W] =
        cat_in[(e*OPERAND_COUNT+k)*OPND_W +: OPND_W];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst || !up_q);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_cat;
    cat_out == $past(cat_exp);
  endproperty
  a_cat: assert property (p_cat) else $error("concat order wrong");
  property p_not;
    not_out == ~$past(not_in);
  endproperty
  a_not: assert property (p_not) else $error("not result wrong");
  property p_and;
    !$past(and_b_scalar) |-> and_out == $past(and_a & and_b);
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_and_sc;
    $past(and_b_scalar) |-> and_out == ($past(and_a) & {ELEMS{$past(and_b[OPND_W-1:0])}});
  endproperty
  a_and_sc: assert property (p_and_sc) else $error("scalar and wrong");
  property p_err_zero;
    slice_err |-> slice_out == '0 && slice_len == '0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error slice not zero");
  property p_bw_len;
    $past(range_mode_select) == 3'b001 && !slice_err |-> slice_len == $past(slice_width);
  endproperty
  a_bw_len: assert property (p_bw_len) else $error("slice length wrong");
  property p_tb_len;
    $past(range_mode_select) == 3'b100 && !slice_err |->
      slice_len == LEN_W'($past(top_off) - $past(bot_off) + 1);
  endproperty
  a_tb_len: assert property (p_tb_len) else $error("derived length wrong");
  property p_lsb_neg;
    $past(range_mode_select == 3'b001 && offset_basis_select == 3'b001 && bot_off < 0)
      |-> slice_err;
  endproperty
  a_lsb_neg: assert property (p_lsb_neg) else $error("negative offset taken");
  property p_msb_pos;
    $past(range_mode_select == 3'b010 && offset_basis_select == 3'b100 && top_off > 0)
      |-> slice_err;
  endproperty
  a_msb_pos: assert property (p_msb_pos) else $error("positive offset taken");
  property p_err_pin;
    range_err_q == slice_err;
  endproperty
  a_err_pin: assert property (p_err_pin) else $error("error pin differs");
  c_err: cover property (slice_err);
  c_scalar: cover property ($past(and_b_scalar) && and_out != '0);
  c_full: cover property (slice_len == LEN_W'(OPND_W));
endmodule

// [tb_top.sv]
// Self-checking bench: register accesses drive the operators and read results back.
`timescale 1ns/1ps
module tb_top;
  localparam logic [1:0] OK = bcs_pkg::RESP_OKAY;
  localparam logic [1:0] ER = bcs_pkg::RESP_SLVERR;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, range_err_q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_mismatch = 0;
  int n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------
  bcs_if bcs_if_inst();
  bcs_dev bcs_dev_inst(.*, .link(bcs_if_inst));
  bcs_src bcs_src_inst(.*, .link(bcs_if_inst), .s_axi_wstrb(4'hF));
  bcs_sva bcs_sva_inst(.sys_clk, .rst, .cat_in(bcs_if_inst.cat_in),
    .cat_out(bcs_if_inst.cat_out), .range_mode_select(bcs_if_inst.range_mode_select),
    .offset_basis_select(bcs_if_inst.offset_basis_select), .top_off(bcs_if_inst.top_off),
    .bot_off(bcs_if_inst.bot_off), .slice_width(bcs_if_inst.slice_width),
    .slice_out(bcs_if_inst.slice_out), .slice_len(bcs_if_inst.slice_len),
    .slice_err(bcs_if_inst.slice_err), .and_a(bcs_if_inst.and_a), .and_b(bcs_if_inst.and_b),
    .and_b_scalar(bcs_if_inst.and_b_scalar), .and_out(bcs_if_inst.and_out),
    .not_in(bcs_if_inst.not_in), .not_out(bcs_if_inst.not_out), .range_err_q);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: response %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n > 100) begin
      n_mismatch++;
      $display("wrong value at %0t: no answer on the bus", $time);
      tally_and_finish();
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      hang(n++);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp_resp(s_axi_bresp, er);
  endtask
  // Two idle edges let a prior write reach the results.
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    repeat (2) @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      hang(n++);
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp_resp(s_axi_rresp, er);
    cmp_word(s_axi_rdata, ed);
  endtask
  // Slice input is 8'h9D, 8'hB6 per element; AND result stays 16'h3048.
  task automatic slice_case(input logic [2:0] m, b, input int t, bo, w, input logic e = 1'b1,
      input logic [15:0] len = '0, o = '0);
    axi_wr(bcs_pkg::ADDR_CTRL, 32'(m) | (32'(b) << 4), OK);
    axi_wr(bcs_pkg::ADDR_TOP_OFF, 32'(t), OK);
    axi_wr(bcs_pkg::ADDR_BOT_OFF, 32'(bo), OK);
    axi_wr(bcs_pkg::ADDR_WIDTH, 32'(w), OK);
    axi_rd(bcs_pkg::ADDR_STATUS, {len, 15'h0000, e}, OK);
    axi_rd(12'h208, {16'h3048, o}, OK);
    cmp_word(32'(range_err_q), 32'(e));
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    axi_rd(bcs_pkg::ADDR_CTRL, bcs_pkg::CTRL_RESET, OK);
    axi_rd(bcs_pkg::ADDR_WIDTH, bcs_pkg::WIDTH_RESET, OK);
    axi_rd(12'h0FC, '0, ER);
    axi_rd(12'h002, '0, ER);
    axi_wr(12'h0F0, 32'h1234_5678, ER);
    axi_wr(bcs_pkg::ADDR_STATUS, 32'hFFFF_FFFF, OK);
    axi_rd(bcs_pkg::ADDR_STATUS, 32'h0001_0000, OK);
    axi_wr(12'h100, 32'h4433_2211, OK);
    axi_wr(12'h104, 32'h8877_6655, OK);
    axi_wr(12'h108, 32'hF0CC_B69D, OK);
    axi_wr(12'h10C, 32'h00A5_3C5A, OK);
    axi_rd(12'h200, 32'h1122_3344, OK);
    axi_rd(12'h204, 32'h5566_7788, OK);
    axi_rd(12'h20C, 32'h0000_FF5A, OK);
    axi_rd(12'h208, 32'h3048_0001, OK);
    axi_wr(bcs_pkg::ADDR_CTRL, 32'h0000_0111, OK);
    axi_rd(12'h208, 32'h5048_0001, OK);
    slice_case(3'b001, 3'b001, -5, 2, 3, 1'b0, 16'h0003, 16'h0507);
    slice_case(3'b010, 3'b100, -1, 0, 4, 1'b0, 16'h0004, 16'h0603);
    slice_case(3'b100, 3'b010, 7, 0, 0, 1'b0, 16'h0008, 16'hB69D);
    slice_case(3'b100, 3'b001, 5, 5, 9, 1'b0, 16'h0001, 16'h0100);
    slice_case(3'b001, 3'b100, 0, -7, 2, 1'b0, 16'h0002, 16'h0201);
    slice_case(3'b001, 3'b001, 0, -1, 2);
    slice_case(3'b010, 3'b100, 1, 0, 1);
    slice_case(3'b010, 3'b010, -1, 0, 1);
    slice_case(3'b001, 3'b001, 0, 6, 3);
    slice_case(3'b100, 3'b001, 2, 3, 1);
    slice_case(3'b001, 3'b001, 0, 0, 0);
    slice_case(3'b011, 3'b001, 0, 0, 1);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    axi_rd(12'h200, '0, OK);
    axi_rd(bcs_pkg::ADDR_CTRL, bcs_pkg::CTRL_RESET, OK);
    tally_and_finish();
  end
endmodule
